/* src/judge_pkg.sv */
// Constants, modes and fault codes shared by the comparator and fault judge
// What this block does
// RQ1 - Above-range result forces decision high, below-range forces decision low.
// RQ2 - A measurement fault yields no comparator decision.
// RQ3 - Comparator enabled at reset; when disabled no decision is shown.
// RQ4 - Decisions appear on control port only after criteria are committed.
// RQ5 - Lamps follow each decision; beeper is optional and off after reset.
// RQ6 - Reference mode judges against reference with separate plus and minus tolerances.
// RQ7 - Writing the positive tolerance preloads the negative with equal magnitude.
// RQ8 - Commit with positive limit below negative limit is refused, error 001.
// RQ9 - Absolute mode judges against stored upper and lower thresholds.
// RQ10 - Any fraction of the result's last digit rounds up before comparing.
// RQ11 - Compare against full-precision entered criteria, not display-rounded values.
// RQ12 - Edits stay pending until commit; otherwise committed values are kept.
// RQ13 - Locally entered criteria select the measurement range automatically.
// RQ14 - Four fault detectors: out-of-range, contact, voltage level, current monitor.
// RQ15 - Fault output asserted for every fault except out-of-range; code keeps it low on current monitor fail.
// RQ16 - Out-of-range flagged with sign outside measurement or display range.
// RQ17 - Contact fault when either contact pair resistance reaches its limit.
// RQ18 - Unstable sense voltage raises its own voltage fault code.
// RQ19 - Contacts fine: current monitor fail shows positive out-of-range, decides high.
// RQ20 - Contact or voltage fail: show its code, no decision, fault output.
// RQ21 - After a settings change show blank result until next measurement.
// RQ22 - Fault code chosen from fixed detection order and current settings.
// RQ23 - Only the first fault in priority order is displayed; all reported.
// RQ24 - Percent beyond 999.999, zero-adjust overflow or converter overflow is out-of-range.
// RQ25 - Auto range: up to 10.009 mOhm gives 10 mOhm, decades, up to 1200.0 Ohm.
// RQ26 - Remotely written criteria leave the measurement range unchanged.
// RQ27 - High above upper limit, low below lower limit, in-limits otherwise.
// RQ28 - Reference limits are reference times one plus each tolerance.
package judge_pkg;
	// Values are micro-ohm counts with extra fraction bits below the last digit
	localparam int VAL_W = 40;
	localparam int FRAC_W = 4;
	// Tolerance in 0.001 % units, signed
	localparam int TOL_W = 24;
	localparam logic [TOL_W-1:0] TOL_SCALE = 24'h0186a0; // 100.000 %
	localparam logic [31:0] PCT_LIMIT = 32'h000f423f; // 999.999 % in 0.001 units
	// Register indices
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_REF = 4'h1;
	localparam logic [3:0] ADDR_TOLP = 4'h2;
	localparam logic [3:0] ADDR_TOLN = 4'h3;
	localparam logic [3:0] ADDR_UPPER = 4'h4;
	localparam logic [3:0] ADDR_LOWER = 4'h5;
	localparam logic [3:0] ADDR_COMMIT = 4'h6;
	localparam logic [3:0] ADDR_STATUS = 4'h7;
	localparam logic [3:0] ADDR_CLIM = 4'h8;
	// Control bits
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_ABS = 1;
	localparam int CTRL_BEEP = 2;
	localparam int CTRL_LOCAL = 3;
	localparam logic [3:0] CTRL_RESET = 4'h1;
	localparam logic [7:0] ERR_LIMITS = 8'h01; // Error 001
	localparam int RANGE_W = 3;
	localparam logic [RANGE_W-1:0] RANGE_RESET = 3'h5; // 1000 Ohm
	// Auto-range decade thresholds in micro-ohm (10.009 mOhm .. 1200.0 Ohm)
	localparam logic [31:0] RANGE_TOP0 = 32'h00002719; // 10009
	localparam logic [31:0] RANGE_TOP1 = 32'h000186fa; // 100090
	localparam logic [31:0] RANGE_TOP2 = 32'h000f45c4; // 1000900
	localparam logic [31:0] RANGE_TOP3 = 32'h0098b9a8; // 10009000
	localparam logic [31:0] RANGE_TOP4 = 32'h05f74090; // 100090000
	localparam logic [31:0] RANGE_TOP5 = 32'h47868c00; // 1200.0 Ohm
	// Decision and display codes
	typedef enum logic [1:0] {DEC_NONE = 2'b00, DEC_HIGH = 2'b01, DEC_IN = 2'b10, DEC_LOW = 2'b11} decision_t;
	typedef enum logic [2:0] {
		SHOW_VALUE = 3'b000, SHOW_OVR_POS = 3'b001, SHOW_OVR_NEG = 3'b010,
		SHOW_CE_HIGH = 3'b011, SHOW_CE_LOW = 3'b100, SHOW_CE_VOLT = 3'b101, SHOW_BLANK = 3'b110
	} show_t;
endpackage : judge_pkg

/* src/comparator_fault_judge.sv */
// Comparator decision and measurement fault classification
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module comparator_fault_judge
	import judge_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Measurement front end
	input wire logic meas_valid,
	input wire logic [VAL_W-1:0] meas_value,
	input wire logic meas_range_over,
	input wire logic meas_range_under,
	input wire logic meas_adc_over,
	input wire logic meas_zero_over,
	input wire logic [31:0] meas_contact_high,
	input wire logic [31:0] meas_contact_low,
	input wire logic meas_volt_unstable,
	input wire logic meas_current_fail,
	input wire logic settings_changed,
	// External control port and panel
	output logic judged_high,
	output logic judged_in,
	output logic judged_low,
	output logic fault_out,
	output logic lamp_high,
	output logic lamp_in,
	output logic lamp_low,
	output logic beep,
	output logic [2:0] show_code,
	output logic [RANGE_W-1:0] range_sel
);
	// Committed and pending criteria
	logic [3:0] ctrl_reg, ctrl_next;
	logic [31:0] ref_reg, ref_next, up_reg, up_next, lo_reg, lo_next;
	logic signed [TOL_W-1:0] tolp_reg, tolp_next, toln_reg, toln_next;
	logic [31:0] pref_reg, pref_next, pup_reg, pup_next, plo_reg, plo_next;
	logic signed [TOL_W-1:0] ptolp_reg, ptolp_next, ptoln_reg, ptoln_next;
	logic [31:0] climh_reg, climh_next, climl_reg, climl_next;
	logic set_reg, set_next;
	logic [7:0] err_reg, err_next;
	logic [RANGE_W-1:0] range_reg, range_next;
	logic [31:0] rdata_reg, rdata_next;
	// Limits over pending values for commit check
	logic signed [63:0] p_hi_lim, p_lo_lim;
	logic [31:0] auto_basis;
	logic [RANGE_W-1:0] auto_range;
	logic commit;

	// Limits of pending values: thresholds in absolute mode, else reference times one plus tolerance
	always_comb
	begin
		p_hi_lim = (ctrl_reg[CTRL_ABS]) ? 64'(pup_reg) * 64'(TOL_SCALE)
			: 64'(pref_reg) * (64'(TOL_SCALE) + 64'(ptolp_reg)); // RQ28
		p_lo_lim = (ctrl_reg[CTRL_ABS]) ? 64'(plo_reg) * 64'(TOL_SCALE)
			: 64'(pref_reg) * (64'(TOL_SCALE) + 64'(ptoln_reg));
		auto_basis = ctrl_reg[CTRL_ABS] ? pup_reg : pref_reg;
		if (auto_basis <= RANGE_TOP0) auto_range = 3'h0; // RQ25
		else if (auto_basis <= RANGE_TOP1) auto_range = 3'h1;
		else if (auto_basis <= RANGE_TOP2) auto_range = 3'h2;
		else if (auto_basis <= RANGE_TOP3) auto_range = 3'h3;
		else if (auto_basis <= RANGE_TOP4) auto_range = 3'h4;
		else auto_range = 3'h5;
		commit = reg_wr && reg_addr == ADDR_COMMIT;
	end

	// Register writes, commit and readback
	always_comb
	begin
		ctrl_next = ctrl_reg;
		ref_next = ref_reg;
		tolp_next = tolp_reg;
		toln_next = toln_reg;
		up_next = up_reg;
		lo_next = lo_reg;
		pref_next = pref_reg;
		ptolp_next = ptolp_reg;
		ptoln_next = ptoln_reg;
		pup_next = pup_reg;
		plo_next = plo_reg;
		climh_next = climh_reg;
		climl_next = climl_reg;
		set_next = set_reg;
		err_next = err_reg;
		range_next = range_reg;
		rdata_next = 32'h0;
		if (reg_wr)
		begin
			unique case (reg_addr)
				ADDR_CTRL: ctrl_next = reg_wdata[3:0];
				ADDR_REF: pref_next = reg_wdata; // RQ12
				ADDR_TOLP:
				begin
					ptolp_next = reg_wdata[TOL_W-1:0];
					ptoln_next = reg_wdata[TOL_W-1] ? reg_wdata[TOL_W-1:0] : -reg_wdata[TOL_W-1:0]; // RQ7
				end
				ADDR_TOLN: ptoln_next = reg_wdata[TOL_W-1:0];
				ADDR_UPPER: pup_next = reg_wdata;
				ADDR_LOWER: plo_next = reg_wdata;
				ADDR_CLIM:
				begin
					climh_next = {16'h0, reg_wdata[15:0]};
					climl_next = {16'h0, reg_wdata[31:16]};
				end
				ADDR_COMMIT:
				begin
					if (p_hi_lim < p_lo_lim)
						err_next = ERR_LIMITS; // RQ8
					else
					begin
						err_next = 8'h0;
						ref_next = pref_reg; // RQ11
						tolp_next = ptolp_reg;
						toln_next = ptoln_reg;
						up_next = pup_reg;
						lo_next = plo_reg;
						set_next = 1'b1;
						if (ctrl_reg[CTRL_LOCAL])
							range_next = auto_range; // RQ13 RQ26
					end
				end
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_CTRL: rdata_next = {28'h0, ctrl_reg};
				ADDR_REF: rdata_next = pref_reg;
				ADDR_TOLP: rdata_next = 32'(ptolp_reg);
				ADDR_TOLN: rdata_next = 32'(ptoln_reg);
				ADDR_UPPER: rdata_next = pup_reg;
				ADDR_LOWER: rdata_next = plo_reg;
				ADDR_STATUS: rdata_next = {16'h0, err_reg, 1'b0, range_reg, set_reg, show_code};
				ADDR_CLIM: rdata_next = {climl_reg[15:0], climh_reg[15:0]};
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= CTRL_RESET; // RQ3 RQ5
			ref_reg <= 32'h0;
			tolp_reg <= '0;
			toln_reg <= '0;
			up_reg <= 32'h0;
			lo_reg <= 32'h0;
			pref_reg <= 32'h0;
			ptolp_reg <= '0;
			ptoln_reg <= '0;
			pup_reg <= 32'h0;
			plo_reg <= 32'h0;
			climh_reg <= 32'h0000ffff;
			climl_reg <= 32'h0000ffff;
			set_reg <= 1'b0;
			err_reg <= 8'h0;
			range_reg <= RANGE_RESET;
			rdata_reg <= 32'h0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			ref_reg <= ref_next;
			tolp_reg <= tolp_next;
			toln_reg <= toln_next;
			up_reg <= up_next;
			lo_reg <= lo_next;
			pref_reg <= pref_next;
			ptolp_reg <= ptolp_next;
			ptoln_reg <= ptoln_next;
			pup_reg <= pup_next;
			plo_reg <= plo_next;
			climh_reg <= climh_next;
			climl_reg <= climl_next;
			set_reg <= set_next;
			err_reg <= err_next;
			range_reg <= range_next;
			rdata_reg <= rdata_next;
		end
	end

	// Judgement of one measurement
	logic [VAL_W-FRAC_W:0] val_round;
	logic signed [79:0] val_scaled, hi_lim, lo_lim;
	logic pct_over, oor_pos, oor_neg, contact_bad;
	logic [1:0] dec_next, dec_reg;
	logic [2:0] show_next, show_reg;
	logic fault_next, fault_reg;
	logic [2:0] lines_next, lines_reg;
	logic beep_next, beep_reg;
	logic signed [63:0] pct_diff;

	always_comb
	begin
		// Round up any fraction below the last digit
		val_round = (VAL_W-FRAC_W+1)'(meas_value[VAL_W-1:FRAC_W]) + (VAL_W-FRAC_W+1)'(|meas_value[FRAC_W-1:0]); // RQ10
		val_scaled = 80'(val_round) * 80'(TOL_SCALE);
		hi_lim = ctrl_reg[CTRL_ABS] ? 80'(up_reg) * 80'(TOL_SCALE)
			: 80'(ref_reg) * (80'(TOL_SCALE) + 80'(tolp_reg)); // RQ6 RQ9 RQ28
		lo_lim = ctrl_reg[CTRL_ABS] ? 80'(lo_reg) * 80'(TOL_SCALE)
			: 80'(ref_reg) * (80'(TOL_SCALE) + 80'(toln_reg));
		// Relative percent in 0.001 units; only meaningful in reference mode
		// Signed throughout, so a result below the reference gives a small negative percent
		pct_diff = (ref_reg == 32'h0) ? 64'sh0
			: 64'((val_scaled - $signed(80'(ref_reg) * 80'(TOL_SCALE))) / $signed(80'(ref_reg)));
		pct_over = !ctrl_reg[CTRL_ABS] && ref_reg != 32'h0
			&& (pct_diff > $signed(64'(PCT_LIMIT)) || pct_diff < -$signed(64'(PCT_LIMIT))); // RQ24
		oor_pos = meas_range_over || meas_adc_over || (meas_zero_over && !meas_range_under)
			|| (pct_over && !pct_diff[63]); // RQ16
		oor_neg = meas_range_under || (pct_over && pct_diff[63]);
		contact_bad = meas_contact_high >= climh_reg || meas_contact_low >= climl_reg; // RQ17
		dec_next = dec_reg;
		show_next = show_reg;
		fault_next = fault_reg;
		if (settings_changed)
		begin
			show_next = SHOW_BLANK; // RQ21
			dec_next = DEC_NONE;
			fault_next = 1'b0;
		end
		else if (meas_valid)
		begin
			// Fixed order: contact, voltage, current, range; first found is shown
			fault_next = contact_bad || meas_volt_unstable; // RQ15 RQ23
			if (contact_bad) // RQ14 RQ22
			begin
				show_next = meas_contact_high >= climh_reg ? SHOW_CE_HIGH : SHOW_CE_LOW;
				dec_next = DEC_NONE; // RQ2 RQ20
			end
			else if (meas_volt_unstable)
			begin
				show_next = SHOW_CE_VOLT; // RQ18
				dec_next = DEC_NONE;
			end
			else if (meas_current_fail || oor_pos)
			begin
				show_next = SHOW_OVR_POS; // RQ19
				dec_next = DEC_HIGH; // RQ1
			end
			else if (oor_neg)
			begin
				show_next = SHOW_OVR_NEG;
				dec_next = DEC_LOW;
			end
			else
			begin
				show_next = SHOW_VALUE;
				if (val_scaled > hi_lim) dec_next = DEC_HIGH; // RQ27
				else if (val_scaled < lo_lim) dec_next = DEC_LOW;
				else dec_next = DEC_IN;
			end
			if (!ctrl_reg[CTRL_ENABLE] || !set_reg)
				dec_next = DEC_NONE; // RQ3 RQ4
		end
		// Port lines and beeper get flip-flops of their own so the port never sees decode glitches
		lines_next = {dec_next == DEC_HIGH, dec_next == DEC_IN, dec_next == DEC_LOW};
		beep_next = meas_valid && !settings_changed && ctrl_reg[CTRL_BEEP] && dec_next != DEC_NONE; // RQ5
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dec_reg <= DEC_NONE;
			show_reg <= SHOW_BLANK;
			fault_reg <= 1'b0;
			lines_reg <= 3'h0;
			beep_reg <= 1'b0; // RQ5
		end
		else
		begin
			dec_reg <= dec_next;
			show_reg <= show_next;
			fault_reg <= fault_next;
			lines_reg <= lines_next;
			beep_reg <= beep_next;
		end
	end

	// Outputs straight from flip-flops; lamps share the flip-flops of the port lines
	assign judged_high = lines_reg[2];
	assign judged_in = lines_reg[1];
	assign judged_low = lines_reg[0];
	assign lamp_high = lines_reg[2]; // RQ5
	assign lamp_in = lines_reg[1];
	assign lamp_low = lines_reg[0];
	assign fault_out = fault_reg;
	assign beep = beep_reg;
	assign show_code = show_reg;
	assign range_sel = range_reg;
	assign reg_rdata = rdata_reg;

	// Checks on what the block drives
	// Steps that the multi-step checks are built from
	sequence meas_taken;
		meas_valid && !settings_changed;
	endsequence
	sequence meas_clean_armed;
		meas_taken ##0 (!contact_bad && !meas_volt_unstable && !meas_current_fail && ctrl_reg[CTRL_ENABLE] && set_reg);
	endsequence
	sequence commit_good;
		commit && !(p_hi_lim < p_lo_lim);
	endsequence

	// A fault line never comes with a decision
	a_fault_no_dec: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
		fault_reg |-> dec_reg == DEC_NONE) else $error("decision during fault");
	// Disabled comparator stays silent
	a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
		$past(!ctrl_reg[CTRL_ENABLE] && meas_valid && !settings_changed) |-> dec_reg == DEC_NONE)
		else $error("decision while disabled");
	// Over range decides high unless a contact or voltage fault ranks above it
	a_over_high: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
		meas_taken ##0 (meas_range_over && !contact_bad && !meas_volt_unstable && ctrl_reg[CTRL_ENABLE] && set_reg)
		|=> dec_reg == DEC_HIGH) else $error("over range not high");
	// Under range decides low when nothing ranks above it
	a_under_low: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
		meas_clean_armed ##0 (meas_range_under && !oor_pos) |=> dec_reg == DEC_LOW)
		else $error("under range not low");
	// Inside both limits the decision is in-limits
	a_in_limits: assert property (@(posedge clk) disable iff (!rst_n) // RQ27
		meas_clean_armed ##0 (!oor_pos && !oor_neg && val_scaled <= hi_lim && val_scaled >= lo_lim)
		|=> dec_reg == DEC_IN) else $error("in limits not judged in");
	// Current monitor alone shows positive over range, decides high and keeps the fault line low
	a_current_high: assert property (@(posedge clk) disable iff (!rst_n) // RQ19
		meas_taken ##0 (meas_current_fail && !contact_bad && !meas_volt_unstable && ctrl_reg[CTRL_ENABLE] && set_reg)
		|=> dec_reg == DEC_HIGH && show_reg == SHOW_OVR_POS && !fault_reg) else $error("current fault not high");
	// Contact fault shows its code and raises the fault line
	a_contact_fault: assert property (@(posedge clk) disable iff (!rst_n) // RQ17
		meas_taken ##0 contact_bad |=> fault_reg && show_reg inside {SHOW_CE_HIGH, SHOW_CE_LOW})
		else $error("contact fault missed");
	// Unstable voltage has a code of its own
	a_volt_code: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
		meas_taken ##0 (!contact_bad && meas_volt_unstable) |=> show_reg == SHOW_CE_VOLT)
		else $error("voltage code missing");
	// Out of range is shown without the fault line
	a_oor_nofault: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
		show_reg inside {SHOW_OVR_POS, SHOW_OVR_NEG} |-> !fault_reg) else $error("fault on out of range");
	// A settings change blanks the display
	a_blank_after: assert property (@(posedge clk) disable iff (!rst_n) // RQ21
		settings_changed |=> show_reg == SHOW_BLANK) else $error("no blank after change");
	// Beeper only sounds after a decided measurement with the beeper on
	a_beep_gate: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
		beep |-> $past(meas_valid && ctrl_reg[CTRL_BEEP]) && (judged_high || judged_in || judged_low))
		else $error("beep without decision");
	// Refused commit flags the error and leaves the criteria in force
	a_commit_refuse: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
		commit && p_hi_lim < p_lo_lim |=> err_reg == ERR_LIMITS && $stable(ref_reg) && $stable(up_reg))
		else $error("bad commit accepted");
	// Accepted commit copies the pending criteria
	a_commit_take: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
		commit_good |=> set_reg && ref_reg == $past(pref_reg) && up_reg == $past(pup_reg) && lo_reg == $past(plo_reg))
		else $error("commit not taken");
	// Without a commit the criteria in force never move
	a_pending_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
		!commit |=> $stable(ref_reg) && $stable(tolp_reg) && $stable(toln_reg) && $stable(up_reg) && $stable(lo_reg))
		else $error("criteria moved without commit");
	// A positive tolerance preloads the negative one with the same magnitude
	a_tol_preload: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
		reg_wr && reg_addr == ADDR_TOLP && !reg_wdata[TOL_W-1] |=> ptoln_reg == -ptolp_reg)
		else $error("negative tolerance not preloaded");
	// A remotely set comparator never moves the range
	a_remote_range: assert property (@(posedge clk) disable iff (!rst_n) // RQ26
		!ctrl_reg[CTRL_LOCAL] |=> $stable(range_reg)) else $error("remote commit moved range");
endmodule : comparator_fault_judge

/* tb/plc_model.sv */
// Controller model that reads the decision and fault lines of the control port
`timescale 1ns/1ps
module plc_model
	import judge_pkg::*;
(
	// Control port lines
	input wire logic judged_high,
	input wire logic judged_in,
	input wire logic judged_low,
	input wire logic fault_out,
	// Decoded view
	output decision_t seen_dec,
	output logic seen_fault
);
	// Two lines at once is no valid decision, so it reads as unknown and never matches
	always_comb
	begin
		seen_fault = fault_out;
		case ({judged_high, judged_in, judged_low})
			3'b000: seen_dec = DEC_NONE;
			3'b100: seen_dec = DEC_HIGH;
			3'b010: seen_dec = DEC_IN;
			3'b001: seen_dec = DEC_LOW;
			default: seen_dec = decision_t'(2'bxx);
		endcase
	end
endmodule : plc_model

/* tb/comparator_fault_judge_bench.sv */
// Self-checking bench for the comparator and fault judge
`timescale 1ns/1ps
module comparator_fault_judge_bench;
	import judge_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic mv = 1'b0;
	logic [VAL_W-1:0] mval = '0;
	logic [5:0] mf = 6'h00; // Over, under, converter, zero, voltage, current
	logic [31:0] ch = 32'h0;
	logic [31:0] cl = 32'h0;
	logic sc = 1'b0;
	logic jh, ji, jl, fo, lh, li, ll, bp, sf;
	logic [2:0] show;
	logic [RANGE_W-1:0] rsel;
	decision_t sd;
	int failures = 0;
	int checks = 0;
	int cyc = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	comparator_fault_judge comparator_fault_judge_i (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .meas_valid(mv), .meas_value(mval), .meas_range_over(mf[5]),
		.meas_range_under(mf[4]), .meas_adc_over(mf[3]), .meas_zero_over(mf[2]), .meas_contact_high(ch),
		.meas_contact_low(cl), .meas_volt_unstable(mf[1]), .meas_current_fail(mf[0]), .settings_changed(sc),
		.judged_high(jh), .judged_in(ji), .judged_low(jl), .fault_out(fo), .lamp_high(lh), .lamp_in(li),
		.lamp_low(ll), .beep(bp), .show_code(show), .range_sel(rsel));
	plc_model plc_model_i (.judged_high(jh), .judged_in(ji), .judged_low(jl), .fault_out(fo), .seen_dec(sd),
		.seen_fault(sf));

	// A hang ends the run here rather than stalling the simulator
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures++;
			close_out();
		end
	end

	task automatic close_out;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic bad(input string m);
		failures++;
		$display("[ERR] %0t %s", $time, m);
	endtask : bad

	task automatic chk_out(input decision_t d, input logic [2:0] s, input logic f);
		checks++;
		if (sd !== d || show !== s || sf !== f || {lh, li, ll} !== {jh, ji, jl})
			bad("decision lines");
	endtask : chk_out

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
			bad("value");
	endtask : chk_val

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wreg

	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rreg

	// One measurement; flags are over, under, converter, zero, voltage, current, contact high, contact low
	task automatic run(input int u, input logic [3:0] fr, input logic [7:0] f, input decision_t d,
		input logic [2:0] s, input logic fl);
		@(posedge clk);
		mv <= 1'b1;
		mval <= (VAL_W'(u) << FRAC_W) | VAL_W'(fr);
		mf <= f[7:2];
		ch <= f[1] ? 32'h00000064 : 32'h00000063;
		cl <= f[0] ? 32'h00000064 : 32'h00000063;
		@(posedge clk);
		mv <= 1'b0;
		#1;
		chk_out(d, s, fl);
	endtask : run

	task automatic t_reset;
		logic [31:0] d;
		chk_out(DEC_NONE, SHOW_BLANK, 1'b0);
		chk_val(32'(rsel), 32'(RANGE_RESET));
		chk_val({31'h0, bp}, 32'h0);
		rreg(ADDR_CTRL, d);
		chk_val(d, 32'h00000001);
		rreg(ADDR_CLIM, d);
		chk_val(d, 32'hffffffff);
		rreg(4'hc, d);
		chk_val(d, 32'h0);
		run(500, 4'h0, 8'h00, DEC_NONE, SHOW_VALUE, 1'b0);
	endtask : t_reset

	task automatic t_abs;
		wreg(ADDR_CTRL, 32'h00000003);
		wreg(ADDR_UPPER, 32'h000003e8);
		wreg(ADDR_LOWER, 32'h000001f4);
		wreg(ADDR_COMMIT, 32'h0);
		run(1001, 4'h0, 8'h00, DEC_HIGH, SHOW_VALUE, 1'b0);
		run(1000, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		run(1000, 4'h1, 8'h00, DEC_HIGH, SHOW_VALUE, 1'b0);
		run(499, 4'hf, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		run(500, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		run(499, 4'h0, 8'h00, DEC_LOW, SHOW_VALUE, 1'b0);
	endtask : t_abs

	// Beep is a single-cycle pulse, so it is checked high in that cycle and low in the next
	task automatic t_beep;
		wreg(ADDR_CTRL, 32'h00000007);
		run(700, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		chk_val({31'h0, bp}, 32'h1);
		@(posedge clk);
		#1;
		chk_val({31'h0, bp}, 32'h0);
	endtask : t_beep

	task automatic t_range;
		wreg(ADDR_CTRL, 32'h0000000b);
		wreg(ADDR_UPPER, 32'h00002719);
		wreg(ADDR_LOWER, 32'h0);
		wreg(ADDR_COMMIT, 32'h0);
		chk_val(32'(rsel), 32'h0);
		wreg(ADDR_UPPER, 32'h0000271a);
		wreg(ADDR_COMMIT, 32'h0);
		chk_val(32'(rsel), 32'h1);
		wreg(ADDR_CTRL, 32'h00000003);
		wreg(ADDR_UPPER, 32'h47868c00);
		wreg(ADDR_COMMIT, 32'h0);
		chk_val(32'(rsel), 32'h1);
	endtask : t_range

	task automatic t_ref;
		logic [31:0] d;
		wreg(ADDR_CTRL, 32'h00000001);
		wreg(ADDR_REF, 32'h000f4240);
		wreg(ADDR_TOLP, 32'h00001388);
		rreg(ADDR_TOLN, d);
		chk_val(d, 32'hffffec78);
		wreg(ADDR_TOLN, 32'hffffd8f0);
		wreg(ADDR_COMMIT, 32'h0);
		run(1050001, 4'h0, 8'h00, DEC_HIGH, SHOW_VALUE, 1'b0);
		run(1050000, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		run(900000, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		run(899999, 4'h0, 8'h00, DEC_LOW, SHOW_VALUE, 1'b0);
		run(20000000, 4'h0, 8'h00, DEC_HIGH, SHOW_OVR_POS, 1'b0);
		wreg(ADDR_TOLP, 32'h000003e8);
		run(1010001, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
	endtask : t_ref

	task automatic t_faults;
		wreg(ADDR_CLIM, 32'h00640064);
		run(1000000, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		run(1000000, 4'h0, 8'h02, DEC_NONE, SHOW_CE_HIGH, 1'b1);
		run(1000000, 4'h0, 8'h01, DEC_NONE, SHOW_CE_LOW, 1'b1);
		run(1000000, 4'h0, 8'h03, DEC_NONE, SHOW_CE_HIGH, 1'b1);
		run(1000000, 4'h0, 8'h08, DEC_NONE, SHOW_CE_VOLT, 1'b1);
		run(1000000, 4'h0, 8'h0c, DEC_NONE, SHOW_CE_VOLT, 1'b1);
		run(1000000, 4'h0, 8'h04, DEC_HIGH, SHOW_OVR_POS, 1'b0);
		run(1000000, 4'h0, 8'h80, DEC_HIGH, SHOW_OVR_POS, 1'b0);
		run(1000000, 4'h0, 8'h40, DEC_LOW, SHOW_OVR_NEG, 1'b0);
		run(1000000, 4'h0, 8'h20, DEC_HIGH, SHOW_OVR_POS, 1'b0);
		run(1000000, 4'h0, 8'h10, DEC_HIGH, SHOW_OVR_POS, 1'b0);
		run(1000000, 4'h0, 8'h82, DEC_NONE, SHOW_CE_HIGH, 1'b1);
	endtask : t_faults

	task automatic t_settings;
		run(1000000, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
		@(posedge clk);
		sc <= 1'b1;
		@(posedge clk);
		sc <= 1'b0;
		#1;
		chk_out(DEC_NONE, SHOW_BLANK, 1'b0);
		run(1000000, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
	endtask : t_settings

	task automatic t_disable;
		wreg(ADDR_CTRL, 32'h0);
		run(1000000, 4'h0, 8'h00, DEC_NONE, SHOW_VALUE, 1'b0);
		wreg(ADDR_CTRL, 32'h00000001);
	endtask : t_disable

	// A refused commit keeps the previous limits in force
	task automatic t_err;
		logic [31:0] d;
		wreg(ADDR_TOLP, 32'hffffb1e0);
		wreg(ADDR_TOLN, 32'h00000000);
		wreg(ADDR_COMMIT, 32'h0);
		rreg(ADDR_STATUS, d);
		chk_val({24'h0, d[15:8]}, {24'h0, ERR_LIMITS});
		run(1040000, 4'h0, 8'h00, DEC_IN, SHOW_VALUE, 1'b0);
	endtask : t_err

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		t_reset();
		t_abs();
		t_beep();
		t_range();
		t_ref();
		t_faults();
		t_settings();
		t_disable();
		t_err();
		close_out();
	end
endmodule : comparator_fault_judge_bench
